/* pga_ref_pkg.sv */
// Constants, field layout and helpers for the front-end control block
package pga_ref_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_GAIN = 8'h00;
  localparam logic [7:0] OFS_INMUX = 8'h04;
  localparam logic [7:0] OFS_REF = 8'h08;
  localparam logic [7:0] OFS_ALT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GAIN_LSB = 0;
  localparam int BYPASS_BIT = 4;
  localparam int INMUX_POS_LSB = 0;
  localparam int INMUX_NEG_LSB = 4;
  localparam int REF_NEG_LSB = 0;
  localparam int REF_POS_LSB = 2;
  localparam int ST_REF_LOW = 0;
  localparam int ST_AMP_LOW = 1;
  localparam int ST_AMP_HIGH = 2;
  localparam int ST_LIVE_LSB = 4;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] INMUX_RST = 8'h10;
  localparam logic [3:0] REF_RST = 4'h5;
  localparam logic [4:0] ALT_RST = 5'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [1:0] REF_SEL_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SEL_SUPPLY = 2'h1;
  localparam logic [1:0] REF_SEL_PAIR0 = 2'h2;
  localparam logic [1:0] REF_SEL_PAIR1 = 2'h3;
  localparam logic [3:0] MUX_VCOM = 4'hE;
  localparam logic [3:0] MUX_OPEN = 4'hF;
  localparam logic [2:0] AMP_MAX_CODE = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLANK_TIME_NS = 128;
  localparam int BLANK_CYCLES =
    (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

  // Analog stage tops out at 32
  function automatic logic [2:0] amp_code(input logic [2:0] gain);
    amp_code = (gain > AMP_MAX_CODE) ? AMP_MAX_CODE : gain;
  endfunction

  // Remaining factor of 2 or 4 done digitally
  function automatic logic [1:0] dig_shift(input logic [2:0] gain);
    logic [2:0] diff;
    diff = gain - amp_code(gain);
    dig_shift = diff[1:0];
  endfunction

endpackage

/* mux_blank_timer.sv */
// Comparator blanking window started by each input multiplexer change
module mux_blank_timer #(
  parameter int CYCLES = pga_ref_pkg::BLANK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic trigger_i,
  output logic active_o
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  logic [W-1:0] count;

  // Retrigger restarts the full window
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= '0;
    end else if (trigger_i) begin
      count <= LOAD;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign active_o = (count != '0);

endmodule

/* alarm_flag.sv */
// One read-only alarm flag: live bit, conversion snapshot, rise event
module alarm_flag (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cond_i,
  input wire logic blank_i,
  input wire logic conv_start_i,
  output logic flag_o,
  output logic snap_o,
  output logic rise_o
);

  logic qual;

  assign qual = cond_i & ~blank_i;

  // Set wins; clear only at a conversion start with condition gone
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_o <= 1'b0;
    end else if (qual) begin
      flag_o <= 1'b1;
    end else if (conv_start_i) begin
      flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap_o <= 1'b0;
    end else if (conv_start_i) begin
      snap_o <= flag_o | qual;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_o <= 1'b0;
    end else begin
      rise_o <= qual & ~flag_o;
    end
  end

endmodule

/* pga_ref_mux_control.sv */
// Gain, bypass, input and reference select and overload alarm control
module pga_ref_mux_control #(
  parameter int BLANK_CYCLES = pga_ref_pkg::BLANK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic [1:0] response_o,
  output logic waitrequest_o,
  input wire logic amp_pos_above_high_i,
  input wire logic amp_neg_above_high_i,
  input wire logic amp_pos_below_low_i,
  input wire logic amp_neg_below_low_i,
  input wire logic ref_below_min_i,
  input wire logic conv_start_i,
  output logic [2:0] amp_gain_code_o,
  output logic [1:0] digital_gain_shift_o,
  output logic amp_bypass_o,
  output logic amp_powerdown_o,
  output logic [3:0] in_pos_sel_o,
  output logic [3:0] in_neg_sel_o,
  output logic inputs_open_o,
  output logic vcom_tie_o,
  output logic [1:0] pos_reference_select_o,
  output logic [1:0] neg_reference_select_o,
  output logic [4:0] alt_func_en_o,
  output logic amp_high_overload_flag_o,
  output logic amp_low_overload_flag_o,
  output logic low_reference_flag_o,
  output logic irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  pga_ref_pkg::bus_state_t bus_state;
  logic [2:0] gain;
  logic bypass;
  logic [7:0] inmux;
  logic [3:0] ref_cfg;
  logic [4:0] alt_cfg;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_stat;
  logic [2:0] flag_snap;
  logic [2:0] flag_rise;
  logic [31:0] next_readdata;
  logic next_hit;
  logic wr_go;
  logic wr_lane0;
  logic mux_trigger;
  logic blank_active;
  logic amp_blank;
  logic [3:0] pos_sel;
  logic [3:0] neg_sel;

  // ****************************************
  // Bus handshake
  // ****************************************
  // Each access waits one cycle, then completes; one idle cycle between
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state <= pga_ref_pkg::BUS_IDLE;
    end else begin
      case (bus_state)
        pga_ref_pkg::BUS_IDLE: begin
          if (read_i || write_i) begin
            bus_state <= pga_ref_pkg::BUS_ACK;
          end
        end
        pga_ref_pkg::BUS_ACK: begin
          bus_state <= pga_ref_pkg::BUS_IDLE;
        end
        default: begin
          bus_state <= pga_ref_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      waitrequest_o <= 1'b1;
    end else if (bus_state == pga_ref_pkg::BUS_IDLE) begin
      waitrequest_o <= ~(read_i | write_i);
    end else begin
      waitrequest_o <= 1'b1;
    end
  end

  // Write lands on the edge where the master sees waitrequest low
  assign wr_go = (bus_state == pga_ref_pkg::BUS_ACK) & write_i;
  assign wr_lane0 = wr_go & byteenable_i[0];

  // ****************************************
  // Read path and address decode
  // ****************************************
  always_comb begin
    next_readdata = 32'h0000_0000;
    next_hit = 1'b1;
    case (address_i)
      pga_ref_pkg::OFS_GAIN: begin
        next_readdata[pga_ref_pkg::GAIN_LSB +: 3] = gain;
        next_readdata[pga_ref_pkg::BYPASS_BIT] = bypass;
      end
      pga_ref_pkg::OFS_INMUX: begin
        next_readdata[7:0] = inmux;
      end
      pga_ref_pkg::OFS_REF: begin
        next_readdata[3:0] = ref_cfg;
      end
      pga_ref_pkg::OFS_ALT: begin
        next_readdata[4:0] = alt_cfg;
      end
      pga_ref_pkg::OFS_STATUS: begin
        next_readdata[pga_ref_pkg::ST_REF_LOW] = flag_snap[0];
        next_readdata[pga_ref_pkg::ST_AMP_LOW] = flag_snap[1];
        next_readdata[pga_ref_pkg::ST_AMP_HIGH] = flag_snap[2];
        next_readdata[pga_ref_pkg::ST_LIVE_LSB] = low_reference_flag_o;
        next_readdata[pga_ref_pkg::ST_LIVE_LSB + 1] =
          amp_low_overload_flag_o;
        next_readdata[pga_ref_pkg::ST_LIVE_LSB + 2] =
          amp_high_overload_flag_o;
      end
      pga_ref_pkg::OFS_IRQ_STAT: begin
        next_readdata[2:0] = irq_stat;
      end
      pga_ref_pkg::OFS_IRQ_MASK: begin
        next_readdata[2:0] = irq_mask;
      end
      default: begin
        next_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (bus_state == pga_ref_pkg::BUS_IDLE) begin
      if (read_i) begin
        readdata_o <= next_readdata;
      end else begin
        readdata_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      response_o <= pga_ref_pkg::RESP_OKAY;
    end else if (bus_state == pga_ref_pkg::BUS_IDLE) begin
      if ((read_i || write_i) && !next_hit) begin
        response_o <= pga_ref_pkg::RESP_SLVERR;
      end else begin
        response_o <= pga_ref_pkg::RESP_OKAY;
      end
    end
  end

  // ****************************************
  // Gain and bypass
  // ****************************************
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gain <= pga_ref_pkg::GAIN_RST[2:0];
      bypass <= pga_ref_pkg::GAIN_RST[pga_ref_pkg::BYPASS_BIT];
    end else if (wr_lane0 && address_i == pga_ref_pkg::OFS_GAIN) begin
      gain <= writedata_i[pga_ref_pkg::GAIN_LSB +: 3];
      bypass <= writedata_i[pga_ref_pkg::BYPASS_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      amp_gain_code_o <= 3'h0;
      digital_gain_shift_o <= 2'h0;
    end else begin
      amp_gain_code_o <= pga_ref_pkg::amp_code(gain);
      digital_gain_shift_o <= pga_ref_pkg::dig_shift(gain);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      amp_bypass_o <= 1'b0;
      amp_powerdown_o <= 1'b0;
    end else begin
      amp_bypass_o <= bypass;
      amp_powerdown_o <= bypass;
    end
  end

  // ****************************************
  // Input multiplexer
  // ****************************************
  // Any change of selection starts a blanking window
  assign mux_trigger = wr_lane0 && address_i == pga_ref_pkg::OFS_INMUX
                       && writedata_i[7:0] != inmux;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inmux <= pga_ref_pkg::INMUX_RST;
    end else if (wr_lane0 && address_i == pga_ref_pkg::OFS_INMUX) begin
      inmux <= writedata_i[7:0];
    end
  end

  assign pos_sel = inmux[pga_ref_pkg::INMUX_POS_LSB +: 4];
  assign neg_sel = inmux[pga_ref_pkg::INMUX_NEG_LSB +: 4];

  // Alternate functions do not gate the selection path
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_pos_sel_o <= 4'h0;
      in_neg_sel_o <= 4'h0;
      inputs_open_o <= 1'b0;
      vcom_tie_o <= 1'b0;
    end else begin
      in_pos_sel_o <= pos_sel;
      in_neg_sel_o <= neg_sel;
      inputs_open_o <= pos_sel == pga_ref_pkg::MUX_OPEN
                       || pos_sel == pga_ref_pkg::MUX_VCOM;
      vcom_tie_o <= pos_sel == pga_ref_pkg::MUX_VCOM;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alt_cfg <= pga_ref_pkg::ALT_RST;
      alt_func_en_o <= pga_ref_pkg::ALT_RST;
    end else begin
      if (wr_lane0 && address_i == pga_ref_pkg::OFS_ALT) begin
        alt_cfg <= writedata_i[4:0];
      end
      alt_func_en_o <= alt_cfg;
    end
  end

  // ****************************************
  // Reference multiplexers
  // ****************************************
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_cfg <= pga_ref_pkg::REF_RST;
    end else if (wr_lane0 && address_i == pga_ref_pkg::OFS_REF) begin
      ref_cfg <= writedata_i[3:0];
    end
  end

  // Codes map to sources per pole: internal, supply, pair 0, pair 1
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pos_reference_select_o <= pga_ref_pkg::REF_SEL_SUPPLY;
      neg_reference_select_o <= pga_ref_pkg::REF_SEL_SUPPLY;
    end else begin
      pos_reference_select_o <=
        ref_cfg[pga_ref_pkg::REF_POS_LSB +: 2];
      neg_reference_select_o <=
        ref_cfg[pga_ref_pkg::REF_NEG_LSB +: 2];
    end
  end

  // ****************************************
  // Alarm monitors
  // ****************************************
  mux_blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .trigger_i(mux_trigger),
    .active_o(blank_active)
  );

  // Powered-down amp gives meaningless comparator outputs
  assign amp_blank = blank_active | amp_powerdown_o;

  alarm_flag u_ref_low (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cond_i(ref_below_min_i),
    .blank_i(1'b0),
    .conv_start_i(conv_start_i),
    .flag_o(low_reference_flag_o),
    .snap_o(flag_snap[0]),
    .rise_o(flag_rise[0])
  );

  alarm_flag u_amp_low (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cond_i(amp_pos_below_low_i | amp_neg_below_low_i),
    .blank_i(amp_blank),
    .conv_start_i(conv_start_i),
    .flag_o(amp_low_overload_flag_o),
    .snap_o(flag_snap[1]),
    .rise_o(flag_rise[1])
  );

  alarm_flag u_amp_high (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cond_i(amp_pos_above_high_i | amp_neg_above_high_i),
    .blank_i(amp_blank),
    .conv_start_i(conv_start_i),
    .flag_o(amp_high_overload_flag_o),
    .snap_o(flag_snap[2]),
    .rise_o(flag_rise[2])
  );

  // ****************************************
  // Interrupts
  // ****************************************
  // Set wins over a write-one clear in the same cycle
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_lane0 && address_i == pga_ref_pkg::OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~writedata_i[2:0];
    end
    next_irq_stat = next_irq_stat | flag_rise;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask <= pga_ref_pkg::IRQ_MASK_RST;
    end else if (wr_lane0 && address_i == pga_ref_pkg::OFS_IRQ_MASK) begin
      irq_mask <= writedata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

endmodule

/* pga_ref_mux_control_sva.sv */
// Assertion checker for the front-end control block
module pga_ref_mux_control_chk #(
  parameter int BLANK_CYCLES = 16
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic waitrequest_o,
  input wire logic amp_pos_above_high_i,
  input wire logic amp_neg_above_high_i,
  input wire logic amp_pos_below_low_i,
  input wire logic amp_neg_below_low_i,
  input wire logic ref_below_min_i,
  input wire logic conv_start_i,
  input wire logic [2:0] amp_gain_code_o,
  input wire logic [1:0] digital_gain_shift_o,
  input wire logic amp_bypass_o,
  input wire logic amp_powerdown_o,
  input wire logic inputs_open_o,
  input wire logic vcom_tie_o,
  input wire logic amp_high_overload_flag_o,
  input wire logic amp_low_overload_flag_o,
  input wire logic low_reference_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // ****************************************
  // Properties
  // ****************************************
  chk_shift_split:
    assert property (digital_gain_shift_o != 2'h0 |->
      amp_gain_code_o == 3'h5 && digital_gain_shift_o != 2'h3)
    else $error("digital gain without full analog gain");
  chk_bypass_pdown:
    assert property (amp_bypass_o == amp_powerdown_o)
    else $error("bypass and powerdown differ");
  chk_high_cause:
    assert property ($rose(amp_high_overload_flag_o) |->
      $past(amp_pos_above_high_i || amp_neg_above_high_i))
    else $error("high flag rose without comparator");
  chk_low_cause:
    assert property ($rose(amp_low_overload_flag_o) |->
      $past(amp_pos_below_low_i || amp_neg_below_low_i))
    else $error("low flag rose without comparator");
  chk_high_hold:
    assert property (amp_high_overload_flag_o && !conv_start_i |=>
      amp_high_overload_flag_o)
    else $error("high flag dropped between conversions");
  chk_low_clear:
    assert property ($fell(amp_low_overload_flag_o) |->
      $past(conv_start_i))
    else $error("low flag cleared without conversion start");
  chk_ref_set:
    assert property (ref_below_min_i |=> low_reference_flag_o)
    else $error("reference flag not set");
  chk_ref_clear:
    assert property ($fell(low_reference_flag_o) |->
      $past(conv_start_i && !ref_below_min_i))
    else $error("reference flag cleared early");
  chk_vcom_open:
    assert property (vcom_tie_o |-> inputs_open_o)
    else $error("mid-supply tie with inputs connected");
  chk_wait_pulse:
    assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for two cycles");
  cov_high: cover property ($rose(amp_high_overload_flag_o));
  cov_ref_clr: cover property ($fell(low_reference_flag_o));
  cov_bypass: cover property ($rose(amp_bypass_o));
endmodule

bind pga_ref_mux_control pga_ref_mux_control_chk #(
  .BLANK_CYCLES(BLANK_CYCLES)
) chk_inst (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .waitrequest_o(waitrequest_o),
  .amp_pos_above_high_i(amp_pos_above_high_i),
  .amp_neg_above_high_i(amp_neg_above_high_i),
  .amp_pos_below_low_i(amp_pos_below_low_i),
  .amp_neg_below_low_i(amp_neg_below_low_i),
  .ref_below_min_i(ref_below_min_i), .conv_start_i(conv_start_i),
  .amp_gain_code_o(amp_gain_code_o),
  .digital_gain_shift_o(digital_gain_shift_o),
  .amp_bypass_o(amp_bypass_o), .amp_powerdown_o(amp_powerdown_o),
  .inputs_open_o(inputs_open_o), .vcom_tie_o(vcom_tie_o),
  .amp_high_overload_flag_o(amp_high_overload_flag_o),
  .amp_low_overload_flag_o(amp_low_overload_flag_o),
  .low_reference_flag_o(low_reference_flag_o)
);

/* pga_ref_mux_control_tb.sv */
// Self-checking testbench for the front-end control block
module pga_ref_mux_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] a, d;
    logic [2:0] amp;
    logic [1:0] sh;
    logic byp;
    logic [1:0] ps, ns;
  } row_t;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [4:0] cmp = 5'h00;
  logic conv_start_i = 1'b0;
  logic [31:0] readdata_o, rdat;
  logic [1:0] response_o, rrsp, digital_gain_shift_o;
  logic [1:0] pos_reference_select_o, neg_reference_select_o;
  logic [2:0] amp_gain_code_o;
  logic [3:0] in_pos_sel_o, in_neg_sel_o;
  logic [4:0] alt_func_en_o;
  logic waitrequest_o, amp_bypass_o, amp_powerdown_o, inputs_open_o;
  logic vcom_tie_o, irq_o, amp_high_overload_flag_o;
  logic amp_low_overload_flag_o, low_reference_flag_o;
  logic [2:0] flags;
  int n_mismatch = 0;
  int compares = 0;
  row_t rows [14] = '{
    '{8'h00, 8'h00, 3'h0, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h01, 3'h1, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h02, 3'h2, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h03, 3'h3, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h04, 3'h4, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h05, 3'h5, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h06, 3'h5, 2'h1, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h07, 3'h5, 2'h2, 1'b0, 2'h1, 2'h1},
    '{8'h00, 8'h17, 3'h5, 2'h2, 1'b1, 2'h1, 2'h1},
    '{8'h00, 8'h01, 3'h1, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h08, 8'h00, 3'h1, 2'h0, 1'b0, 2'h0, 2'h0},
    '{8'h08, 8'h0E, 3'h1, 2'h0, 1'b0, 2'h3, 2'h2},
    '{8'h08, 8'h05, 3'h1, 2'h0, 1'b0, 2'h1, 2'h1},
    '{8'h08, 8'h0B, 3'h1, 2'h0, 1'b0, 2'h2, 2'h3}
  };
  assign flags = {amp_high_overload_flag_o, amp_low_overload_flag_o,
    low_reference_flag_o};

  always #4 mclk_i = ~mclk_i;

  pga_ref_mux_control #(.BLANK_CYCLES(4)) pga_ref_mux_control_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(4'hF), .readdata_o(readdata_o),
    .response_o(response_o), .waitrequest_o(waitrequest_o),
    .amp_pos_above_high_i(cmp[3]), .amp_neg_above_high_i(cmp[4]),
    .amp_pos_below_low_i(cmp[1]), .amp_neg_below_low_i(cmp[2]),
    .ref_below_min_i(cmp[0]), .conv_start_i(conv_start_i),
    .amp_gain_code_o(amp_gain_code_o),
    .digital_gain_shift_o(digital_gain_shift_o),
    .amp_bypass_o(amp_bypass_o), .amp_powerdown_o(amp_powerdown_o),
    .in_pos_sel_o(in_pos_sel_o), .in_neg_sel_o(in_neg_sel_o),
    .inputs_open_o(inputs_open_o), .vcom_tie_o(vcom_tie_o),
    .pos_reference_select_o(pos_reference_select_o),
    .neg_reference_select_o(neg_reference_select_o),
    .alt_func_en_o(alt_func_en_o),
    .amp_high_overload_flag_o(amp_high_overload_flag_o),
    .amp_low_overload_flag_o(amp_low_overload_flag_o),
    .low_reference_flag_o(low_reference_flag_o), .irq_o(irq_o)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_val(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, g);
    check_val(nm, 32'(e), 32'(g));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, d);
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= {24'h00_0000, d};
    write_i <= wr;
    read_i <= !wr;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge mclk_i);
    end while (waitrequest_o !== 1'b0);
    rdat = readdata_o;
    rrsp = response_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask

  task automatic pulse();
    conv_start_i <= 1'b1;
    cyc(1);
    conv_start_i <= 1'b0;
    cyc(1);
  endtask

  // Raise one comparator, check flag, irq, clear and snapshot
  task automatic alarm(input int k, input int b, input logic m);
    bus(1'b1, pga_ref_pkg::OFS_IRQ_MASK, m ? 8'h07 : 8'h00);
    cyc(1);
    cmp[b] <= 1'b1;
    // Flag and rise event on the same edge, then status bit, then registered irq
    cyc(4);
    check_bit("flag", 1'b1, flags[k]);
    check_bit("irq", m, irq_o);
    pulse();
    check_bit("held", 1'b1, flags[k]);
    cmp[b] <= 1'b0;
    cyc(2);
    pulse();
    check_bit("cleared", 1'b0, flags[k]);
    bus(1'b0, pga_ref_pkg::OFS_STATUS, 8'h00);
    check_val("status", 32'h1 << k, rdat);
    bus(1'b1, pga_ref_pkg::OFS_IRQ_STAT, 8'h07);
    cyc(2);
    check_bit("irq off", 1'b0, irq_o);
    $display("alarm %0d input %0d done", k, b);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    cyc(12);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      cyc(2);
      check_val("amp", 32'(rows[i].amp), 32'(amp_gain_code_o));
      check_val("shift", 32'(rows[i].sh), 32'(digital_gain_shift_o));
      check_bit("bypass", rows[i].byp, amp_bypass_o);
      check_bit("pdown", rows[i].byp, amp_powerdown_o);
      check_val("pos ref", 32'(rows[i].ps), 32'(pos_reference_select_o));
      check_val("neg ref", 32'(rows[i].ns), 32'(neg_reference_select_o));
      bus(1'b0, rows[i].a, 8'h00);
      check_val("readback", 32'(rows[i].d), rdat);
      check_val("resp ok", 32'(pga_ref_pkg::RESP_OKAY), 32'(rrsp));
    end
    $display("table done");
    arst_n_i <= 1'b0;
    cyc(2);
    check_val("pos rst", 32'h1, 32'(pos_reference_select_o));
    check_val("neg rst", 32'h1, 32'(neg_reference_select_o));
    arst_n_i <= 1'b1;
    bus(1'b0, pga_ref_pkg::OFS_REF, 8'h00);
    check_val("ref reg", 32'h5, rdat);
    $display("reset done");
    alarm(0, 0, 1'b1);
    alarm(1, 1, 1'b1);
    alarm(1, 2, 1'b0);
    alarm(2, 3, 1'b1);
    alarm(2, 4, 1'b0);
    bus(1'b1, pga_ref_pkg::OFS_INMUX, 8'h1E);
    cyc(1);
    cmp[4] <= 1'b1;
    cyc(1);
    cmp[4] <= 1'b0;
    cyc(2);
    check_bit("blanked", 1'b0, amp_high_overload_flag_o);
    check_bit("open", 1'b1, inputs_open_o);
    check_bit("vcom", 1'b1, vcom_tie_o);
    check_val("pos sel", 32'hE, 32'(in_pos_sel_o));
    cyc(8);
    alarm(2, 4, 1'b1);
    $display("blanking done");
    bus(1'b1, pga_ref_pkg::OFS_ALT, 8'h1F);
    cyc(2);
    check_val("alt", 32'h1F, 32'(alt_func_en_o));
    check_val("sel kept", 32'hE, 32'(in_pos_sel_o));
    check_val("neg kept", 32'h1, 32'(in_neg_sel_o));
    bus(1'b1, pga_ref_pkg::OFS_INMUX, 8'h1F);
    cyc(2);
    check_bit("open only", 1'b1, inputs_open_o);
    check_bit("no vcom", 1'b0, vcom_tie_o);
    bus(1'b1, pga_ref_pkg::OFS_STATUS, 8'hFF);
    bus(1'b0, pga_ref_pkg::OFS_STATUS, 8'h00);
    check_val("status ro", 32'h4, rdat);
    bus(1'b0, 8'h1C, 8'h00);
    check_val("unmapped", 32'h0, rdat);
    check_val("resp", 32'(pga_ref_pkg::RESP_SLVERR), 32'(rrsp));
    $display("access done");
    give_verdict();
  end
endmodule
